// ===== hw/csl_in_filter.sv
// Two-flop synchroniser and glitch filter for each serial bus pin.
// Assumes the pins are asynchronous to core_clk_in and idle high.
`timescale 1ns/1ps
module csl_in_filter
    import csl_pkg::*;
#(
    parameter int W = 2
) (
    input  wire logic         core_clk_in,
    input  wire logic         reset_n_in,
    input  wire logic         clk_en_in,
    input  wire logic [W-1:0] pin_in,
    output wire logic [W-1:0] filt_out
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic       meta_q;
            logic       sync_q;
            logic [3:0] cnt_q;
            logic [3:0] cnt_d;
            logic       filt_q;
            logic       filt_d;

            // A new level is accepted only after it has held one cycle
            // longer than the widest pulse that must be rejected.
            always_comb begin
                cnt_d  = cnt_q;
                filt_d = filt_q;
                if (sync_q == filt_q) begin
                    cnt_d = 4'h0;
                end else if (cnt_q == GLITCH_LIM) begin
                    filt_d = sync_q;
                    cnt_d  = 4'h0;
                end else begin
                    cnt_d = cnt_q + 4'h1;
                end
            end

            always_ff @(posedge core_clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    meta_q <= 1'b1;
                    sync_q <= 1'b1;
                    cnt_q  <= 4'h0;
                    filt_q <= 1'b1;
                end else if (clk_en_in) begin
                    meta_q <= pin_in[i];
                    sync_q <= meta_q;
                    cnt_q  <= cnt_d;
                    filt_q <= filt_d;
                end
            end

            assign filt_out[i] = filt_q;
        end
    endgenerate
endmodule

// ===== hw/csl_meas_seq.sv
// Measurement sequencer: temperature, then X, Y and Z, one time slot each.
// Assumes the analog converter output is valid at the end of each slot.
`timescale 1ns/1ps
module csl_meas_seq
    import csl_pkg::*;
#(
    parameter int SLOT_CYC = MEAS_TIME_CYC / MEAS_STEPS
) (
    input  wire logic       core_clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       clk_en_in,
    input  wire logic       start_in,
    output logic            busy_out,
    output logic            step_out,
    output logic [1:0]      step_idx_out,
    output logic            done_out
);
    localparam logic [23:0] SLOT_LAST = 24'(SLOT_CYC - 1);
    localparam logic [1:0]  IDX_LAST  = 2'(MEAS_STEPS - 1);

    logic        busy_q;
    logic        busy_d;
    logic [23:0] cnt_q;
    logic [23:0] cnt_d;
    logic [1:0]  idx_q;
    logic [1:0]  idx_d;
    logic        slot_end;

    assign slot_end = busy_q && (cnt_q == SLOT_LAST);

    always_comb begin
        busy_d = busy_q;
        cnt_d  = cnt_q;
        idx_d  = idx_q;
        if (start_in && !busy_q) begin
            busy_d = 1'b1;
            cnt_d  = 24'h000000;
            idx_d  = 2'h0;
        end else if (slot_end) begin
            cnt_d = 24'h000000;
            idx_d = idx_q + 2'h1;
            if (idx_q == IDX_LAST) begin
                busy_d = 1'b0;
            end
        end else if (busy_q) begin
            cnt_d = cnt_q + 24'h000001;
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            busy_q <= 1'b0;
            cnt_q  <= 24'h000000;
            idx_q  <= 2'h0;
        end else if (clk_en_in) begin
            busy_q <= busy_d;
            cnt_q  <= cnt_d;
            idx_q  <= idx_d;
        end
    end

    assign busy_out     = busy_q;
    assign step_out     = slot_end;
    assign step_idx_out = idx_q;
    assign done_out     = slot_end && (idx_q == IDX_LAST);
endmodule

// ===== hw/csl_pkg.sv
// Shared constants and types for the compass serial slave and mode controller.
// Assumes a single core clock of 250 MHz; all times are converted from it.
package csl_pkg;

    localparam int CLK_PERIOD_PS = 4000;

    // Bus input glitch rejection: pulses of this width or less are dropped.
    localparam int GLITCH_NS  = 50;
    localparam int GLITCH_CYC = (GLITCH_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [3:0] GLITCH_LIM = 4'(GLITCH_CYC);

    // Whole measurement (temperature plus three axes), typical figure.
    localparam int MEAS_TIME_NS  = 12560000;
    localparam int MEAS_TIME_CYC = MEAS_TIME_NS / (CLK_PERIOD_PS / 1000);
    localparam int MEAS_STEPS = 4;

    // Slave address: fixed high part then the two select pins.
    localparam logic [4:0] SLV_ADDR_FIXED = 5'h07;

    // Register addresses.
    localparam logic [7:0] ADDR_STATUS = 8'hC0;
    localparam logic [7:0] ADDR_TEMP   = 8'hC1;
    localparam logic [7:0] ADDR_XRES   = 8'hC2;
    localparam logic [7:0] ADDR_YRES   = 8'hC3;
    localparam logic [7:0] ADDR_ZRES   = 8'hC4;
    localparam logic [7:0] ADDR_MODE   = 8'hE0;
    localparam logic [7:0] ADDR_XOFS   = 8'hE1;
    localparam logic [7:0] ADDR_YOFS   = 8'hE2;
    localparam logic [7:0] ADDR_ZOFS   = 8'hE3;
    localparam logic [7:0] ADDR_XGAIN  = 8'hE4;
    localparam logic [7:0] ADDR_YGAIN  = 8'hE5;
    localparam logic [7:0] ADDR_ZGAIN  = 8'hE6;

    // Mode setting register fields.
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 1;
    localparam int WEN_LSB  = 3;
    localparam int WEN_MSB  = 7;
    localparam logic [1:0] CODE_MEAS = 2'h0;
    // Status register bit positions.
    localparam int ST_INT_BIT = 0;
    localparam int ST_WEN_BIT = 1;

    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [3:0] BITS_BYTE = 4'h8;
    localparam logic [3:0] BIT_LAST  = 4'h7;

    typedef enum logic [1:0] {
        MODE_PD,
        MODE_MEAS,
        MODE_EEP
    } csl_mode_t;

    typedef enum logic [2:0] {
        BUS_IDLE,
        BUS_ADDR,
        BUS_ADDR_ACK,
        BUS_WR_BYTE,
        BUS_WR_ACK,
        BUS_RD_BYTE,
        BUS_RD_ACK
    } csl_bus_t;

endpackage

// ===== hw/csl_top.sv
// Compass two-wire serial slave, register file and operating-mode control.
// Assumes SCL/SDA arrive from external pull-up wires and the converter
// outputs are synchronous to core_clk_in.
`timescale 1ns/1ps
module csl_top
    import csl_pkg::*;
#(
    parameter int         SLOT_CYC = MEAS_TIME_CYC / MEAS_STEPS,
    parameter logic [1:0] CODE_PD  = 2'h3,
    parameter logic [1:0] CODE_EEP = 2'h2,
    parameter logic [4:0] WEN_KEY  = 5'h15
) (
    input  wire logic       core_clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       clk_en_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    input  wire logic       addr_sel_hi_pin_in,
    input  wire logic       addr_sel_lo_pin_in,
    input  wire logic [7:0] temp_adc_in,
    input  wire logic [7:0] x_adc_in,
    input  wire logic [7:0] y_adc_in,
    input  wire logic [7:0] z_adc_in,
    output logic            int_out,
    output logic            meas_active_out,
    output logic            eeprom_mode_out,
    output logic            eeprom_wr_en_out,
    output logic [7:0]      x_offset_out,
    output logic [7:0]      y_offset_out,
    output logic [7:0]      z_offset_out,
    output logic [3:0]      x_gain_out,
    output logic [3:0]      y_gain_out,
    output logic [3:0]      z_gain_out
);
    logic [1:0] filt;
    logic [1:0] sel_meta_q;
    logic [1:0] sel_sync_q;
    logic       seq_busy;
    logic       seq_step;
    logic [1:0] seq_idx;
    logic       seq_done;
    logic       seq_start;

    csl_in_filter #(.W(2)) u_filt (
        .core_clk_in (core_clk_in),
        .reset_n_in  (reset_n_in),
        .clk_en_in   (clk_en_in),
        .pin_in      ({scl_in, sda_in}),
        .filt_out    (filt)
    );

    csl_meas_seq #(.SLOT_CYC(SLOT_CYC)) u_seq (
        .core_clk_in  (core_clk_in),
        .reset_n_in   (reset_n_in),
        .clk_en_in    (clk_en_in),
        .start_in     (seq_start),
        .busy_out     (seq_busy),
        .step_out     (seq_step),
        .step_idx_out (seq_idx),
        .done_out     (seq_done)
    );

    // Address select pins are static straps but still come from outside.
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sel_meta_q <= 2'h0;
            sel_sync_q <= 2'h0;
        end else if (clk_en_in) begin
            sel_meta_q <= {addr_sel_hi_pin_in, addr_sel_lo_pin_in};
            sel_sync_q <= sel_meta_q;
        end
    end

    csl_bus_t   bus_q, bus_d;
    csl_mode_t  mode_q, mode_d;
    logic       scl_p_q, sda_p_q;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic       rw_q, rw_d;
    logic       first_q, first_d;
    logic       mack_q, mack_d;
    logic       oe_q, oe_d;
    logic [7:0] addr_q, addr_d;
    logic       int_q, int_d;
    logic [4:0] wen_q, wen_d;
    logic [7:0] temp_q, temp_d, xr_q, xr_d, yr_q, yr_d, zr_q, zr_d;
    logic [7:0] xo_q, xo_d, yo_q, yo_d, zo_q, zo_d;
    logic [3:0] xg_q, xg_d, yg_q, yg_d, zg_q, zg_d;
    logic [7:0] rd_data;
    logic [1:0] mode_code;
    logic       scl_f, sda_f, start_c, stop_c, rise, fall;

    assign scl_f   = filt[1];
    assign sda_f   = filt[0];
    // Edge detection on the filtered bus levels.
    assign start_c = scl_f && scl_p_q && sda_p_q && !sda_f;
    assign stop_c  = scl_f && scl_p_q && !sda_p_q && sda_f;
    assign rise    = scl_f && !scl_p_q;
    assign fall    = !scl_f && scl_p_q;

    // Group wrap: results C0..C4 and settings E0..E6 roll to their base.
    function automatic logic [7:0] next_addr(input logic [7:0] a);
        if (a == ADDR_ZRES) begin
            next_addr = ADDR_STATUS;
        end else if (a == ADDR_ZGAIN) begin
            next_addr = ADDR_MODE;
        end else begin
            next_addr = a + 8'h01;
        end
    endfunction

    always_comb begin
        case (mode_q)
            MODE_MEAS: mode_code = CODE_MEAS;
            MODE_EEP:  mode_code = CODE_EEP;
            default:   mode_code = CODE_PD;
        endcase
    end

    // Every register stays readable whatever the mode.
    always_comb begin
        rd_data = BYTE_ZERO;
        case (addr_q)
            ADDR_STATUS: begin
                rd_data[ST_INT_BIT] = int_q;
                rd_data[ST_WEN_BIT] = (wen_q == WEN_KEY);
            end
            ADDR_TEMP:  rd_data = temp_q;
            ADDR_XRES:  rd_data = xr_q;
            ADDR_YRES:  rd_data = yr_q;
            ADDR_ZRES:  rd_data = zr_q;
            ADDR_MODE: begin
                rd_data[WEN_MSB:WEN_LSB]   = wen_q;
                rd_data[MODE_MSB:MODE_LSB] = mode_code;
            end
            ADDR_XOFS:  rd_data = xo_q;
            ADDR_YOFS:  rd_data = yo_q;
            ADDR_ZOFS:  rd_data = zo_q;
            ADDR_XGAIN: rd_data = {4'h0, xg_q};
            ADDR_YGAIN: rd_data = {4'h0, yg_q};
            ADDR_ZGAIN: rd_data = {4'h0, zg_q};
            default:    rd_data = BYTE_ZERO;
        endcase
    end

    always_comb begin
        logic       int_set;
        logic       int_clr;
        logic       wr_now;
        logic       rd_load;
        logic [1:0] code;
        int_set   = 1'b0;
        int_clr   = 1'b0;
        wr_now    = 1'b0;
        rd_load   = 1'b0;
        code      = sh_q[MODE_MSB:MODE_LSB];
        seq_start = 1'b0;
        bus_d = bus_q;  mode_d = mode_q;  cnt_d = cnt_q;  sh_d = sh_q;
        rw_d = rw_q;  first_d = first_q;  mack_d = mack_q;  oe_d = oe_q;
        addr_d = addr_q;  wen_d = wen_q;
        temp_d = temp_q;  xr_d = xr_q;  yr_d = yr_q;  zr_d = zr_q;
        xo_d = xo_q;  yo_d = yo_q;  zo_d = zo_q;
        xg_d = xg_q;  yg_d = yg_q;  zg_d = zg_q;

        if (start_c) begin
            bus_d = BUS_ADDR;
            cnt_d = 4'h0;
            oe_d  = 1'b0;
        end else if (stop_c) begin
            bus_d = BUS_IDLE;
            oe_d  = 1'b0;
        end else if (rise) begin
            if (bus_q == BUS_ADDR || bus_q == BUS_WR_BYTE) begin
                sh_d  = {sh_q[6:0], sda_f};
                cnt_d = cnt_q + 4'h1;
            end else if (bus_q == BUS_RD_ACK) begin
                mack_d = !sda_f;
            end
        end else if (fall) begin
            case (bus_q)
                BUS_ADDR: if (cnt_q == BITS_BYTE) begin
                    if (sh_q[7:1] == {SLV_ADDR_FIXED, sel_sync_q}) begin
                        bus_d = BUS_ADDR_ACK;
                        rw_d  = sh_q[0];
                        oe_d  = 1'b1;
                    end else begin
                        bus_d = BUS_IDLE;
                    end
                end
                BUS_ADDR_ACK: begin
                    cnt_d = 4'h0;
                    if (rw_q) begin
                        rd_load = 1'b1;
                    end else begin
                        bus_d   = BUS_WR_BYTE;
                        first_d = 1'b1;
                        oe_d    = 1'b0;
                    end
                end
                BUS_WR_BYTE: if (cnt_q == BITS_BYTE) begin
                    bus_d = BUS_WR_ACK;
                    oe_d  = 1'b1;
                    if (first_q) begin
                        addr_d  = sh_q;
                        first_d = 1'b0;
                    end else begin
                        wr_now = 1'b1;
                        addr_d = next_addr(addr_q);
                    end
                end
                BUS_WR_ACK: begin
                    bus_d = BUS_WR_BYTE;
                    cnt_d = 4'h0;
                    oe_d  = 1'b0;
                end
                BUS_RD_BYTE: begin
                    // Data changes only after SCL has gone low.
                    if (cnt_q == BIT_LAST) begin
                        bus_d = BUS_RD_ACK;
                        oe_d  = 1'b0;
                    end else begin
                        cnt_d = cnt_q + 4'h1;
                        sh_d  = {sh_q[6:0], 1'b0};
                        oe_d  = !sh_q[6];
                    end
                end
                BUS_RD_ACK: begin
                    cnt_d = 4'h0;
                    if (mack_q) begin
                        rd_load = 1'b1;
                    end else begin
                        bus_d = BUS_IDLE;
                    end
                end
                default: bus_d = BUS_IDLE;
            endcase
        end

        if (rd_load) begin
            bus_d  = BUS_RD_BYTE;
            sh_d   = rd_data;
            oe_d   = !rd_data[7];
            addr_d = next_addr(addr_q);
            // Only the address actually sent decides the clear.
            if (addr_q >= ADDR_TEMP && addr_q <= ADDR_ZRES) begin
                int_clr = 1'b1;
            end
        end

        if (wr_now) begin
            case (addr_q)
                ADDR_MODE: begin
                    wen_d = sh_q[WEN_MSB:WEN_LSB];
                    if (code == CODE_PD) begin
                        mode_d = MODE_PD;
                    // A measurement cut short by power-down still runs to its end;
                    // no new mode starts until it has, so modes never overlap.
                    end else if (mode_q == MODE_PD && !seq_busy) begin
                        if (code == CODE_MEAS && !int_q) begin
                            mode_d    = MODE_MEAS;
                            seq_start = 1'b1;
                            xr_d = BYTE_ZERO;
                            yr_d = BYTE_ZERO;
                            zr_d = BYTE_ZERO;
                        end else if (code == CODE_EEP) begin
                            mode_d = MODE_EEP;
                            xr_d = BYTE_ZERO;
                            yr_d = BYTE_ZERO;
                            zr_d = BYTE_ZERO;
                        end
                    end
                end
                ADDR_XOFS:  xo_d = sh_q;
                ADDR_YOFS:  yo_d = sh_q;
                ADDR_ZOFS:  zo_d = sh_q;
                ADDR_XGAIN: xg_d = sh_q[3:0];
                ADDR_YGAIN: yg_d = sh_q[3:0];
                ADDR_ZGAIN: zg_d = sh_q[3:0];
                default: ;
            endcase
        end

        if (seq_step) begin
            case (seq_idx)
                2'h0:    temp_d = temp_adc_in;
                2'h1:    xr_d   = x_adc_in;
                2'h2:    yr_d   = y_adc_in;
                default: zr_d   = z_adc_in;
            endcase
        end
        if (seq_done) begin
            mode_d  = MODE_PD;
            int_set = 1'b1;
        end
        // A completion in the same cycle as a result read is kept.
        int_d = int_set || (int_q && !int_clr);
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bus_q  <= BUS_IDLE;
            mode_q <= MODE_PD;
            scl_p_q <= 1'b1;  sda_p_q <= 1'b1;
            cnt_q <= 4'h0;  sh_q <= BYTE_ZERO;  rw_q <= 1'b0;
            first_q <= 1'b0;  mack_q <= 1'b0;  oe_q <= 1'b0;
            addr_q <= BYTE_ZERO;  int_q <= 1'b0;  wen_q <= 5'h00;
            temp_q <= BYTE_ZERO;  xr_q <= BYTE_ZERO;
            yr_q <= BYTE_ZERO;  zr_q <= BYTE_ZERO;
            // Settings are cleared here and nowhere else.
            xo_q <= BYTE_ZERO;  yo_q <= BYTE_ZERO;  zo_q <= BYTE_ZERO;
            xg_q <= 4'h0;  yg_q <= 4'h0;  zg_q <= 4'h0;
        end else if (clk_en_in) begin
            bus_q <= bus_d;  mode_q <= mode_d;
            scl_p_q <= scl_f;  sda_p_q <= sda_f;
            cnt_q <= cnt_d;  sh_q <= sh_d;  rw_q <= rw_d;
            first_q <= first_d;  mack_q <= mack_d;  oe_q <= oe_d;
            addr_q <= addr_d;  int_q <= int_d;  wen_q <= wen_d;
            temp_q <= temp_d;  xr_q <= xr_d;  yr_q <= yr_d;  zr_q <= zr_d;
            xo_q <= xo_d;  yo_q <= yo_d;  zo_q <= zo_d;
            xg_q <= xg_d;  yg_q <= yg_d;  zg_q <= zg_d;
        end
    end

    // Open-drain: the line is only ever pulled low.
    assign sda_out          = 1'b0;
    assign sda_oe_out       = oe_q;
    assign int_out          = int_q;
    assign meas_active_out  = seq_busy;
    assign eeprom_mode_out  = (mode_q == MODE_EEP);
    assign eeprom_wr_en_out = (mode_q == MODE_EEP) && (wen_q == WEN_KEY);
    assign x_offset_out     = xo_q;
    assign y_offset_out     = yo_q;
    assign z_offset_out     = zo_q;
    assign x_gain_out       = xg_q;
    assign y_gain_out       = yg_q;
    assign z_gain_out       = zg_q;
endmodule

// ===== sim/csl_bus_master.sv
// Behavioural two-wire bus master driving the pins of csl_top.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
module csl_bus_master #(
    parameter int T_LOW  = 1300,
    parameter int T_HIGH = 600
) (
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_oe_out
);
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    // Data moves mid low phase only; fast-mode minimum times are kept.
    task automatic bit_io(input logic b, output logic r);
        #(T_LOW / 2) sda_oe_out = !b;
        #(T_LOW / 2) scl_out = 1'b1;
        #(T_HIGH / 2) r = sda_in;
        #(T_HIGH / 2) scl_out = 1'b0;
    endtask
    task automatic start();
        #(T_LOW / 2) sda_oe_out = 1'b0;
        #(T_LOW / 2) scl_out = 1'b1;
        #(T_HIGH) sda_oe_out = 1'b1;
        #(T_HIGH) scl_out = 1'b0;
    endtask
    task automatic stop();
        #(T_LOW / 2) sda_oe_out = 1'b1;
        #(T_LOW / 2) scl_out = 1'b1;
        #(T_HIGH) sda_oe_out = 1'b0;
        #(T_HIGH) scl_out = 1'b1;
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic recv(output logic [7:0] d, input logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(!ack, r);
    endtask
endmodule

// ===== sim/csl_top_asserts.sv
// Assertion checker for csl_top, bound to every instance of it.
// Assumes one clock domain with the asynchronous active-low reset.
`timescale 1ns/1ps
module csl_top_asserts
    import csl_pkg::*;
#(
    parameter int SLOT_CYC = MEAS_TIME_CYC / MEAS_STEPS
) (
    input wire logic       core_clk_in,
    input wire logic       reset_n_in,
    input wire logic       scl_in,
    input wire logic       sda_oe_out,
    input wire logic       int_out,
    input wire logic       meas_active_out,
    input wire logic       eeprom_mode_out,
    input wire logic [7:0] x_offset_out,
    input wire logic [3:0] x_gain_out
);
    logic [31:0] run_d;
    logic [31:0] run_q;
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!reset_n_in);
    // A counter bounds the run, since a repeat of this length would be unrolled.
    always_comb run_d = meas_active_out ? run_q + 32'h1 : 32'h0;
    always_ff @(posedge core_clk_in or negedge reset_n_in)
        if (!reset_n_in) run_q <= 32'h0;
        else run_q <= run_d;
    a_reset_quiet: assert property ($rose(reset_n_in) |-> !int_out && !sda_oe_out)
        else $error("Outputs active after reset.");
    a_oe_low_scl: assert property ($changed(sda_oe_out) |-> !scl_in)
        else $error("Data drive changed while clock high.");
    a_mode_excl: assert property (!(meas_active_out && eeprom_mode_out))
        else $error("Two modes at once.");
    a_settings_hold: assert property ($changed(meas_active_out) |->
        $stable(x_offset_out) && $stable(x_gain_out))
        else $error("Settings changed on mode change.");
    a_meas_int_low: assert property ($rose(meas_active_out) |-> !$past(int_out))
        else $error("Measurement began with interrupt high.");
    a_int_on_done: assert property ($rose(int_out) |->
        !meas_active_out && $past(meas_active_out, 2))
        else $error("Interrupt rose without a measurement end.");
    a_meas_span: assert property ($fell(meas_active_out) |->
        run_q >= 32'(MEAS_STEPS * SLOT_CYC - 2) && run_q <= 32'(MEAS_STEPS * SLOT_CYC + 2))
        else $error("Measurement length wrong.");
    a_int_fall_read: assert property ($fell(int_out) |-> !scl_in)
        else $error("Interrupt fell outside a read load.");
endmodule
bind csl_top csl_top_asserts #(.SLOT_CYC(SLOT_CYC)) i_csl_top_asserts (
    .core_clk_in, .reset_n_in, .scl_in, .sda_oe_out, .int_out, .meas_active_out,
    .eeprom_mode_out, .x_offset_out, .x_gain_out);

// ===== sim/tb.sv
// Self-checking bench for csl_top with a bus master model.
// Assumes csl_pkg, the design and the checker are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) check_eq(32'(g), 32'(e))
module tb;
    import csl_pkg::*;
    localparam int LIMIT = 99000;
    localparam logic [1:0] EEP_CODE = 2'h2;
    logic        core_clk_in = 1'b0;
    logic        reset_n_in  = 1'b0;
    logic        sel_hi      = 1'b1;
    logic        sel_lo      = 1'b0;
    logic [7:0]  adc [4]     = '{8'h78, 8'h1E, 8'hC3, 8'h5A};
    // Each row: byte written from the gain group onward, then the value it must show.
    logic [15:0] rows [5]    = '{16'hA606, 16'h5B0B, 16'hFC0C, 16'h0000, 16'h3D3D};
    logic        scl, m_oe, dev_oe, dev_sda, sda_w, ack, irq, busy, eep, eep_wr;
    logic [7:0]  rd, x_ofs, y_ofs, z_ofs;
    logic [3:0]  x_g, y_g, z_g;
    int          fail_count  = 0;
    int          comparisons = 0;
    int          cycles      = 0;
    assign sda_w = (dev_oe ? dev_sda : 1'b1) & !m_oe;
    csl_bus_master i_csl_bus_master (.sda_in(sda_w), .scl_out(scl), .sda_oe_out(m_oe));
    csl_top #(.SLOT_CYC(50), .CODE_EEP(EEP_CODE)) i_csl_top (
        .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .clk_en_in(1'b1),
        .scl_in(scl), .sda_in(sda_w), .sda_out(dev_sda), .sda_oe_out(dev_oe),
        .addr_sel_hi_pin_in(sel_hi), .addr_sel_lo_pin_in(sel_lo),
        .temp_adc_in(adc[0]), .x_adc_in(adc[1]), .y_adc_in(adc[2]), .z_adc_in(adc[3]),
        .int_out(irq), .meas_active_out(busy), .eeprom_mode_out(eep), .eeprom_wr_en_out(eep_wr),
        .x_offset_out(x_ofs), .y_offset_out(y_ofs), .z_offset_out(z_ofs),
        .x_gain_out(x_g), .y_gain_out(y_g), .z_gain_out(z_g));
    always #2 core_clk_in = ~core_clk_in;
    task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic put(input logic [7:0] b, input logic exp_ack);
        i_csl_bus_master.send(b, ack);
        `CHK(ack, exp_ack);
    endtask
    function automatic logic [7:0] seen(input int i);
        case (i)
            0: return {4'h0, x_g};
            1: return {4'h0, y_g};
            2: return {4'h0, z_g};
            3: return {7'h00, busy};
            default: return x_ofs;
        endcase
    endfunction
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (8) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        repeat (20) @(posedge core_clk_in);
        `CHK({irq, dev_oe, busy, x_ofs, y_ofs, z_ofs}, 27'h0000000);
        i_csl_bus_master.start();
        put({SLV_ADDR_FIXED, !sel_hi, sel_lo, 1'b0}, 1'b0);
        i_csl_bus_master.stop();
        i_csl_bus_master.start();
        put({SLV_ADDR_FIXED, sel_hi, sel_lo, 1'b0}, 1'b1);
        put(ADDR_MODE, 1'b1);
        put(8'h00, 1'b1);
        i_csl_bus_master.stop();
        for (int n = 0; n < 400 && irq !== 1'b1; n++) @(posedge core_clk_in);
        `CHK({irq, busy}, 2'h2);
        // Settings go in while powered down; the mode byte is a refused request.
        i_csl_bus_master.start();
        put({SLV_ADDR_FIXED, sel_hi, sel_lo, 1'b0}, 1'b1);
        put(ADDR_XGAIN, 1'b1);
        foreach (rows[i]) put(rows[i][15:8], 1'b1);
        i_csl_bus_master.stop();
        foreach (rows[i]) `CHK(seen(i), rows[i][7:0]);
        i_csl_bus_master.start();
        put({SLV_ADDR_FIXED, sel_hi, sel_lo, 1'b0}, 1'b1);
        put(ADDR_TEMP, 1'b1);
        `CHK(irq, 1'b1);
        i_csl_bus_master.start();
        put({SLV_ADDR_FIXED, sel_hi, sel_lo, 1'b1}, 1'b1);
        for (int i = 0; i < 4; i++) begin
            i_csl_bus_master.recv(rd, i < 3);
            `CHK(rd, adc[i]);
        end
        i_csl_bus_master.stop();
        `CHK(irq, 1'b0);
        // EEPROM mode is entered from power-down with the write-enable field left closed.
        i_csl_bus_master.start();
        put({SLV_ADDR_FIXED, sel_hi, sel_lo, 1'b0}, 1'b1);
        put(ADDR_MODE, 1'b1);
        put({6'h00, EEP_CODE}, 1'b1);
        i_csl_bus_master.stop();
        `CHK({eep, eep_wr, busy}, 3'h4);
        // A reset in mid-run must drop EEPROM mode and clear the X offset and all three gains.
        @(posedge core_clk_in);
        reset_n_in <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        `CHK({eep, eep_wr, x_ofs, x_g, y_g, z_g}, 22'h000000);
        tally_and_finish();
    end
endmodule
